// *** logic/amp_ctl.sv ***
/*
  Controller end: AXI4-Lite slave that issues register accesses to the
  amplifier and drives its bit and frame clocks.
  Assumes one aclk shared with the device end over amp_link_if.
*/
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module amp_ctl
  import amp_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  amp_link_if.ctl          link,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq_out
);

  typedef struct packed {
    logic           aw_got;
    logic [4:0]     aw_addr;
    logic           w_got;
    logic [31:0]    wdata;
    logic           bvalid;
    logic [1:0]     bresp;
    logic           rvalid;
    logic [31:0]    rdata;
    logic [1:0]     rresp;
    amp_ctl_state_e state;
    logic           we;
    logic [7:0]     addr;
    logic [7:0]     wbyte;
    logic [7:0]     rbyte;
    logic [1:0]     istat;
    logic [1:0]     imask;
    logic           clk_en;
    logic [3:0]     div;
    logic           bclk;
    logic [5:0]     bits;
    logic           fclk;
    logic           dirq_prev;
  } amp_ctl_s;

  amp_ctl_s st_ff;
  amp_ctl_s nxt_st;
  logic     do_wr;
  logic [1:0] ev;

  always_comb begin
    nxt_st = st_ff;
    ev     = 2'h0;

    // Write channels: capture address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_got  = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata;
    end
    do_wr = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
    if (s_axi_bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // Device access sequencer
    case (st_ff.state)
      AMP_ST_IDLE: begin
        nxt_st.state = AMP_ST_IDLE;
      end
      AMP_ST_REQ: begin
        if (link.reg_ack) begin
          nxt_st.state = AMP_ST_IDLE;
          nxt_st.rbyte = st_ff.we ? st_ff.rbyte : link.reg_rdata;
          ev[AMP_IS_DONE] = 1'b1;
        end
      end
      default: nxt_st.state = AMP_ST_IDLE;
    endcase

    // Register writes
    if (do_wr) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = AMP_AXI_OKAY;
      case (st_ff.aw_addr)
        AMP_C_CMD: begin
          if (st_ff.state == AMP_ST_IDLE && st_ff.wdata[0] && s_axi_wstrb[0]) begin
            nxt_st.state = AMP_ST_REQ;
            nxt_st.we    = st_ff.wdata[1];
            nxt_st.addr  = st_ff.wdata[15:8];
            nxt_st.wbyte = st_ff.wdata[23:16];
          end
        end
        AMP_C_STAT:  nxt_st.bresp = AMP_AXI_OKAY;
        AMP_C_ISTAT: nxt_st.istat = st_ff.istat & ~st_ff.wdata[1:0];
        AMP_C_IMASK: nxt_st.imask = st_ff.wdata[1:0];
        AMP_C_CLK:   nxt_st.clk_en = st_ff.wdata[0];
        default:     nxt_st.bresp = AMP_AXI_SLVERR;
      endcase
    end

    // Sticky events; set wins over a write-one clear
    ev[AMP_IS_DIRQ] = link.irq && !st_ff.dirq_prev;
    nxt_st.dirq_prev = link.irq;
    nxt_st.istat = nxt_st.istat | ev;

    // Reads
    if (s_axi_rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = AMP_AXI_OKAY;
      case (s_axi_araddr)
        AMP_C_CMD:   nxt_st.rdata = {8'h00, st_ff.wbyte, st_ff.addr, 6'h00, st_ff.we, 1'b0};
        AMP_C_STAT:  nxt_st.rdata = {16'h0000, st_ff.rbyte, 6'h00, link.irq,
                                     st_ff.state == AMP_ST_REQ};
        AMP_C_ISTAT: nxt_st.rdata = {30'h0, st_ff.istat};
        AMP_C_IMASK: nxt_st.rdata = {30'h0, st_ff.imask};
        AMP_C_CLK:   nxt_st.rdata = {31'h0, st_ff.clk_en};
        default: begin
          nxt_st.rdata = 32'h0;
          nxt_st.rresp = AMP_AXI_SLVERR;
        end
      endcase
    end

    // Audio clock divider: 64 bit clocks per frame
    if (!st_ff.clk_en && !st_ff.bclk) begin  // A high half always finishes
      nxt_st.div  = 4'h0;
      nxt_st.bclk = 1'b0;
      nxt_st.bits = 6'h0;
      nxt_st.fclk = 1'b0;
    end else if (st_ff.div == 4'(AMP_BCLK_HALF - 1)) begin
      nxt_st.div  = 4'h0;
      nxt_st.bclk = !st_ff.bclk;
      if (st_ff.bclk) begin
        // Frame clock changes in the same cycle as a falling bit-clock edge
        if (st_ff.bits == 6'(AMP_FRAME_HALF - 1)) begin
          nxt_st.bits = 6'h0;
          nxt_st.fclk = !st_ff.fclk;
        end else begin
          nxt_st.bits = st_ff.bits + 6'h1;
        end
      end
    end else begin
      nxt_st.div = st_ff.div + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff       <= '0;
      st_ff.state <= AMP_ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready    = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready     = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_bvalid     = st_ff.bvalid;
  assign s_axi_bresp      = st_ff.bresp;
  assign s_axi_arready    = !st_ff.rvalid;
  assign s_axi_rvalid     = st_ff.rvalid;
  assign s_axi_rdata      = st_ff.rdata;
  assign s_axi_rresp      = st_ff.rresp;
  assign irq_out          = |(st_ff.istat & st_ff.imask);
  assign link.reg_req     = st_ff.state == AMP_ST_REQ;
  assign link.reg_we      = st_ff.we;
  assign link.reg_addr    = st_ff.addr;
  assign link.reg_wdata   = st_ff.wbyte;
  assign link.bit_clock   = st_ff.bclk;
  assign link.frame_clock = st_ff.fclk;

endmodule : amp_ctl

// *** logic/amp_pkg.sv ***
/*
  Shared constants and types for the amplifier register bank and its
  controller: register offsets, field positions, reset values and counts.
  Assumes both ends and the interface are compiled after this package.
*/
// What this block does
// - Eight interrupt enables, all reset to one
// - Watchdog flag bit 7, write one clears
// - Bit-clock unstable flag bit 6, read clears
// - PLL unlock flag bit 5, read clears
// - Protection flags bits 4..0, read clear, reset zero
// - Eight-bit read/write write checksum, reset zero
// - Live read-only protection status, six bits
// - Word length: 24, 20, 18, 16 bits
// - Bit-clock ratio codes 32fs to 256fs, reset 64fs
// - Sample-rate codes, reset 48k/44.1k, 001 unsupported
// - Auto-detect returns detected rate and ratio
// - Clock loss detection while enable bit 7
// - Bit-clock check while enable bit 6
// - Bit 4 selects DSP mode A or B
// - Offset bit picks first or second edge
// - Frame format codes I2S through 32 slots
package amp_pkg;

  // ----------------------------------------------------------------
  // Device register map
  // ----------------------------------------------------------------
  localparam logic [7:0] AMP_OFS_IEN     = 8'h04;
  localparam logic [7:0] AMP_OFS_IFLAG   = 8'h05;
  localparam logic [7:0] AMP_OFS_CSUM    = 8'h06;
  localparam logic [7:0] AMP_OFS_LIVE    = 8'h09;
  localparam logic [7:0] AMP_OFS_WORD    = 8'h10;
  localparam logic [7:0] AMP_OFS_FMT     = 8'h11;

  localparam logic [7:0] AMP_RST_IEN     = 8'hFF;
  localparam logic [7:0] AMP_RST_IFLAG   = 8'h00;
  localparam logic [7:0] AMP_RST_CSUM    = 8'h00;
  localparam logic [7:0] AMP_RST_WORD    = 8'h13;  // 24 bit, 64fs, 48k
  localparam logic [7:0] AMP_RST_FMT     = 8'hE0;  // Loss, check, detect on; I2S

  // Flag and field positions
  localparam int AMP_BIT_WDT      = 7;
  localparam int AMP_BIT_BCK_UNST = 6;
  localparam int AMP_BIT_LOSS_EN  = 7;
  localparam int AMP_BIT_CHK_EN   = 6;
  localparam int AMP_BIT_DET_EN   = 5;
  localparam int AMP_BIT_DSP_B    = 4;
  localparam int AMP_BIT_OFFSET   = 3;
  localparam logic [7:0] AMP_RC_MASK = 8'h7F;  // Read-clear flags

  // Word length codes
  localparam logic [1:0] AMP_WL_24 = 2'h0;
  localparam logic [1:0] AMP_WL_20 = 2'h1;
  localparam logic [1:0] AMP_WL_18 = 2'h2;
  localparam logic [1:0] AMP_WL_16 = 2'h3;

  // Frame format codes
  localparam logic [2:0] AMP_FF_I2S   = 3'h0;
  localparam logic [2:0] AMP_FF_LJ    = 3'h1;
  localparam logic [2:0] AMP_FF_RJ    = 3'h2;
  localparam logic [2:0] AMP_FF_DSP   = 3'h3;
  localparam logic [2:0] AMP_FF_TDM8  = 3'h4;
  localparam logic [2:0] AMP_FF_TDM16 = 3'h5;
  localparam logic [2:0] AMP_FF_TDM32 = 3'h6;

  // Checksum polynomial, x^8 + x^2 + x + 1
  localparam logic [7:0] AMP_CRC_POLY = 8'h07;

  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam int AMP_LOSS_CYCLES  = 64;  // Cycles without an edge
  localparam int AMP_LOSS_W       = 8;
  localparam int AMP_BCLK_HALF    = 4;   // Controller divider half period
  localparam int AMP_FRAME_HALF   = 32;  // Bit clocks per frame half, 64fs

  // ----------------------------------------------------------------
  // Controller register map (AXI4-Lite byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] AMP_C_CMD    = 5'h00;
  localparam logic [4:0] AMP_C_STAT   = 5'h04;
  localparam logic [4:0] AMP_C_ISTAT  = 5'h08;
  localparam logic [4:0] AMP_C_IMASK  = 5'h0C;
  localparam logic [4:0] AMP_C_CLK    = 5'h10;
  localparam int AMP_IS_DONE = 0;
  localparam int AMP_IS_DIRQ = 1;
  localparam logic [1:0] AMP_AXI_OKAY   = 2'h0;
  localparam logic [1:0] AMP_AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    AMP_ST_IDLE = 2'b01,
    AMP_ST_REQ  = 2'b10
  } amp_ctl_state_e;

  // WRITE_CHECKSUM step over one written byte
  function automatic logic [7:0] amp_write_checksum(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ AMP_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : amp_write_checksum

endpackage : amp_pkg

// *** logic/amp_link_if.sv ***
/*
  Register port and audio clocks between controller and amplifier.
  Assumes one shared aclk; request held until a one-cycle ack.
*/
`timescale 1ns/1ps
interface amp_link_if;
  logic       reg_req;      // Request held until ack
  logic       reg_we;       // One for write
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_ack;      // One-cycle answer
  logic [7:0] reg_rdata;    // Valid with ack on reads
  logic       irq;          // Device interrupt level
  logic       bit_clock;
  logic       frame_clock;

  modport dev (input reg_req, input reg_we, input reg_addr, input reg_wdata,
               output reg_ack, output reg_rdata, output irq,
               input bit_clock, input frame_clock);
  modport ctl (output reg_req, output reg_we, output reg_addr, output reg_wdata,
               input reg_ack, input reg_rdata, input irq,
               output bit_clock, output frame_clock);
endinterface : amp_link_if

// *** logic/amp_regs.sv ***
/*
  Amplifier interrupt and audio format register bank, device end.
  Assumes events and live status come from logic on aclk; the audio
  clocks come from the link and are synchronised here.
*/
`timescale 1ns/1ps
module amp_regs
  import amp_pkg::*;
#(
  parameter int LOSS_CYCLES = AMP_LOSS_CYCLES
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  amp_link_if.dev         link,
  input  wire logic [7:0] event_pulses,
  input  wire logic [5:0] live_status,
  input  wire logic [2:0] detected_ratio,
  input  wire logic [2:0] detected_rate,
  output logic      [1:0] audio_word_length,
  output logic      [2:0] bitclk_ratio,
  output logic      [2:0] sample_rate_code,
  output logic      [2:0] frame_format,
  output logic            dsp_mode_b,
  output logic            frame_offset,
  output logic            bitclk_loss,
  output logic            frameclk_loss
);

  localparam int LW = $clog2(LOSS_CYCLES + 1);  // Loss counter width

  typedef struct packed {
    logic [7:0]            ien;
    logic [7:0]            iflag;
    logic [7:0]            csum;
    logic [7:0]            word;
    logic [7:0]            fmt;
    logic                  ack;
    logic [7:0]            rdata;
    logic [1:0]            bsync;
    logic [1:0]            frame_sync;
    logic                  bprev;
    logic                  fprev;
    logic [LW-1:0]         bcnt;
    logic [LW-1:0]         fcnt;
    logic                  bloss;
    logic                  floss;
  } amp_dev_s;

  localparam logic [LW-1:0] LOSS_LIM = LW'(LOSS_CYCLES);

  amp_dev_s st_ff;
  amp_dev_s nxt_st;

  logic       take;
  logic [7:0] rd_val;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (link.reg_addr)
      AMP_OFS_IEN:   rd_val = st_ff.ien;
      AMP_OFS_IFLAG: rd_val = st_ff.iflag;
      AMP_OFS_CSUM:  rd_val = st_ff.csum;
      AMP_OFS_LIVE:  rd_val = {2'h0, live_status};
      AMP_OFS_WORD:  rd_val = st_ff.fmt[AMP_BIT_DET_EN]
                              ? {st_ff.word[7:6], detected_ratio, detected_rate}
                              : st_ff.word;
      AMP_OFS_FMT:   rd_val = st_ff.fmt;
      default:       rd_val = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    take   = link.reg_req && !st_ff.ack;
    nxt_st.ack = take;

    // Event set vector; bit-clock unstable only while checking
    set_vec = event_pulses;
    set_vec[AMP_BIT_BCK_UNST] = event_pulses[AMP_BIT_BCK_UNST]
                                && st_ff.fmt[AMP_BIT_CHK_EN];

    // Clears: read clears bits 6..0, write one clears bit 7
    clr_vec = 8'h00;
    if (take && !link.reg_we && link.reg_addr == AMP_OFS_IFLAG) begin
      clr_vec = AMP_RC_MASK;
    end
    if (take && link.reg_we && link.reg_addr == AMP_OFS_IFLAG) begin
      clr_vec[AMP_BIT_WDT] = link.reg_wdata[AMP_BIT_WDT];
    end
    // Set wins over a clear in the same cycle
    nxt_st.iflag = (st_ff.iflag & ~clr_vec) | set_vec;

    if (take) begin
      nxt_st.rdata = link.reg_we ? st_ff.rdata : rd_val;
    end

    // Register writes
    if (take && link.reg_we) begin
      nxt_st.csum = amp_write_checksum(st_ff.csum, link.reg_wdata);
      case (link.reg_addr)
        AMP_OFS_IEN:  nxt_st.ien  = link.reg_wdata;
        AMP_OFS_CSUM: nxt_st.csum = link.reg_wdata;
        AMP_OFS_WORD: nxt_st.word = link.reg_wdata;
        AMP_OFS_FMT:  nxt_st.fmt  = link.reg_wdata;
        default:      nxt_st.csum = nxt_st.csum;
      endcase
    end

    // Clock synchronisers and edge detection
    nxt_st.bsync = {st_ff.bsync[0], link.bit_clock};
    nxt_st.frame_sync = {st_ff.frame_sync[0], link.frame_clock};
    nxt_st.bprev = st_ff.bsync[1];
    nxt_st.fprev = st_ff.frame_sync[1];

    // Loss detectors: count cycles with no edge
    if (!st_ff.fmt[AMP_BIT_LOSS_EN] || st_ff.bsync[1] != st_ff.bprev) begin
      nxt_st.bcnt = '0;
    end else if (st_ff.bcnt != LOSS_LIM) begin
      nxt_st.bcnt = st_ff.bcnt + 1'b1;
    end
    if (!st_ff.fmt[AMP_BIT_LOSS_EN] || st_ff.frame_sync[1] != st_ff.fprev) begin
      nxt_st.fcnt = '0;
    end else if (st_ff.fcnt != LOSS_LIM) begin
      nxt_st.fcnt = st_ff.fcnt + 1'b1;
    end
    nxt_st.bloss = st_ff.fmt[AMP_BIT_LOSS_EN] && (nxt_st.bcnt == LOSS_LIM);
    nxt_st.floss = st_ff.fmt[AMP_BIT_LOSS_EN] && (nxt_st.fcnt == LOSS_LIM);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff       <= '0;
      st_ff.ien   <= AMP_RST_IEN;
      st_ff.iflag <= AMP_RST_IFLAG;
      st_ff.csum  <= AMP_RST_CSUM;
      st_ff.word  <= AMP_RST_WORD;
      st_ff.fmt   <= AMP_RST_FMT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.reg_ack      = st_ff.ack;
  assign link.reg_rdata    = st_ff.rdata;
  assign link.irq          = |(st_ff.iflag & st_ff.ien);
  assign audio_word_length = st_ff.word[7:6];
  assign bitclk_ratio      = st_ff.fmt[AMP_BIT_DET_EN] ? detected_ratio : st_ff.word[5:3];
  assign sample_rate_code  = st_ff.fmt[AMP_BIT_DET_EN] ? detected_rate : st_ff.word[2:0];
  assign frame_format      = st_ff.fmt[2:0];
  assign dsp_mode_b        = st_ff.fmt[AMP_BIT_DSP_B];
  assign frame_offset      = st_ff.fmt[AMP_BIT_OFFSET];
  assign bitclk_loss       = st_ff.bloss;
  assign frameclk_loss     = st_ff.floss;

endmodule : amp_regs

// *** sim/amp_link_asserts.sv ***
/*
  Checker for the amplifier link: register handshake, read data, interrupt.
  Assumes one aclk and a synchronous active-low reset beside the interface.
*/
`timescale 1ns/1ps
module amp_link_asserts
  import amp_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       reg_req,
  input wire logic       reg_we,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_ack,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq,
  input wire logic       bit_clock,
  input wire logic       frame_clock
);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  logic [7:0] en_ff;
  logic [7:0] en_now;
  logic       wr_ien;
  logic       mapped;

  // Enables as the device sees them this cycle
  assign wr_ien = reg_ack && reg_we && (reg_addr == AMP_OFS_IEN);
  assign en_now = wr_ien ? reg_wdata : en_ff;
  assign mapped = reg_addr inside {AMP_OFS_IEN, AMP_OFS_IFLAG, AMP_OFS_CSUM,
                                   AMP_OFS_LIVE, AMP_OFS_WORD, AMP_OFS_FMT};

  // Shadow of the enable register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_ff <= AMP_RST_IEN;
    end else if (wr_ien) begin
      en_ff <= reg_wdata;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_ack_after_take: assert property ($rose(reg_req) |=> reg_ack)
    else $error("no ack one cycle after request");
  a_ack_single: assert property (reg_ack |=> !reg_ack && !reg_req)
    else $error("ack or request lingers");
  a_ack_needs_req: assert property (!reg_req |=> !reg_ack)
    else $error("ack without request");
  a_req_held: assert property (reg_req && !reg_ack |=>
      reg_req && $stable({reg_we, reg_addr, reg_wdata}))
    else $error("request changed before ack");
  a_enable_readback: assert property (reg_ack && !reg_we && reg_addr == AMP_OFS_IEN |->
      reg_rdata == en_ff)
    else $error("enable readback wrong");
  a_unmapped_zero: assert property (reg_ack && !reg_we && !mapped |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_irq_masked: assert property (en_now == 8'h00 |-> !irq)
    else $error("irq high with all sources disabled");
  a_rdata_only_read: assert property ($changed(reg_rdata) |-> reg_ack && !reg_we)
    else $error("read data moved outside a read");
  a_bitclk_half: assert property ($changed(bit_clock) |=> $stable(bit_clock) [*3])
    else $error("bit clock half period short");

  // Main scenarios reached
  c_dev_write: cover property (reg_ack && reg_we);
  c_flag_read: cover property (reg_ack && !reg_we && reg_addr == AMP_OFS_IFLAG && reg_rdata != 0);
  c_irq_rise: cover property ($rose(irq));
  c_frame: cover property ($rose(frame_clock));
endmodule : amp_link_asserts

// *** sim/tb_amp_irq_and_audio_format_regs.sv ***
/*
  Bench joining controller and amplifier register bank over the link.
  Assumes amp_pkg, amp_link_if, both ends and the checker compile first.
*/
`timescale 1ns/1ps
`define CHK(G, E) begin total_checks++; if ((G) !== (E)) begin miscompares++; \
  $display("BAD %0t got %h exp %h", $time, G, E); end end
module tb_amp_irq_and_audio_format_regs
  import amp_pkg::*;
;
  logic        aclk;
  logic        aresetn = 0;
  logic [4:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic        awvalid = 0, wvalid = 0, arvalid = 0, bready = 1, rready = 1;
  logic        awready, wready, bvalid, arready, rvalid, irq_out;
  logic [1:0]  bresp, rresp, resp;
  logic [7:0]  ev = 0, dv;
  logic [5:0]  live = 0;
  logic [2:0]  dratio = 3'h2, drate = 3'h3, o_ratio, o_rate, o_ff;
  logic [1:0]  o_wl;
  logic        o_dsp, o_off, o_bl, o_fl;
  int          miscompares = 0, total_checks = 0, cycles = 0;
  int          m_ien = 255, m_flag = 0, m_csum = 0, m_word = 'h13, m_fmt = 'hE0;
  int          rates[$] = '{0, 2, 3, 4, 5, 6, 7};

  amp_link_if u_amp_link_if ();
  amp_regs #(.LOSS_CYCLES(300)) u_amp_regs (.aclk(aclk), .aresetn(aresetn),
    .link(u_amp_link_if.dev), .event_pulses(ev), .live_status(live),
    .detected_ratio(dratio), .detected_rate(drate), .audio_word_length(o_wl),
    .bitclk_ratio(o_ratio), .sample_rate_code(o_rate), .frame_format(o_ff),
    .dsp_mode_b(o_dsp), .frame_offset(o_off), .bitclk_loss(o_bl), .frameclk_loss(o_fl));
  amp_ctl u_amp_ctl (.aclk(aclk), .aresetn(aresetn), .link(u_amp_link_if.ctl),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq_out(irq_out));
  amp_link_asserts u_amp_link_asserts (.aclk(aclk), .aresetn(aresetn),
    .reg_req(u_amp_link_if.reg_req), .reg_we(u_amp_link_if.reg_we),
    .reg_addr(u_amp_link_if.reg_addr), .reg_wdata(u_amp_link_if.reg_wdata),
    .reg_ack(u_amp_link_if.reg_ack), .reg_rdata(u_amp_link_if.reg_rdata),
    .irq(u_amp_link_if.irq), .bit_clock(u_amp_link_if.bit_clock),
    .frame_clock(u_amp_link_if.frame_clock));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  // Running checksum of one written byte
  function automatic int crc(input int c, input int d);
    c = (c ^ d) & 255;
    repeat (8) c = ((c << 1) ^ ((c & 128) ? 7 : 0)) & 255;
    return c;
  endfunction : crc

  // AXI write, both channels offered together
  task automatic axw(input logic [4:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1;
    w = 1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awready) begin aw = 0; awvalid <= 0; end
      if (w && wready) begin w = 0; wvalid <= 0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
  endtask : axw

  // AXI read into rd and resp
  task automatic axr(input logic [4:0] a);
    araddr <= a;
    arvalid <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
  endtask : axr

  // Device access through the controller, checked against the model
  task automatic dev(input logic we, input logic [7:0] a, input logic [7:0] d);
    int e;
    axw(AMP_C_CMD, {8'h00, d, a, 6'h00, we, 1'b1});
    do axr(AMP_C_STAT); while (rd[0] !== 1'b0);
    e = 0;
    if (we) begin
      m_csum = (a == AMP_OFS_CSUM) ? d : crc(m_csum, d);
      if (a == AMP_OFS_IEN) m_ien = d;
      if (a == AMP_OFS_IFLAG) m_flag &= ~(d & 8'h80);
      if (a == AMP_OFS_WORD) m_word = d;
      if (a == AMP_OFS_FMT) m_fmt = d;
    end else begin
      case (a)
        AMP_OFS_IEN:   e = m_ien;
        AMP_OFS_IFLAG: e = m_flag;
        AMP_OFS_CSUM:  e = m_csum;
        AMP_OFS_LIVE:  e = live;
        AMP_OFS_WORD:  e = m_fmt[5] ? {m_word[7:6], dratio, drate} : m_word;
        AMP_OFS_FMT:   e = m_fmt;
        default:       e = 0;
      endcase
      if (a == AMP_OFS_IFLAG) m_flag &= 8'h80;
      `CHK(rd[15:8], e[7:0])
    end
  endtask : dev

  // One-cycle event on one source
  task automatic pulse(input int b);
    ev <= 8'(1 << b);
    if (b != 6 || m_fmt[6]) m_flag |= 1 << b;
    @(posedge aclk);
    ev <= 8'h00;
    repeat (2) @(posedge aclk);
  endtask : pulse

  // Clock generator
  initial begin
    aclk = 0;
    forever #12.5 aclk = ~aclk;
  end

  // Hang limit
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin miscompares++; report_and_stop(); end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h3556));
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    `CHK({o_wl, o_ratio, o_rate, o_ff, o_dsp, o_off}, {AMP_WL_24, 6'h13, AMP_FF_I2S, 2'h0})
    foreach (rates[i]) dev(0, 8'(4 + i), 8'h00);
    dev(0, AMP_OFS_WORD, 8'h00);
    dev(0, AMP_OFS_FMT, 8'h00);
    axr(5'h14);
    `CHK({resp, rd}, {AMP_AXI_SLVERR, 32'h0})
    axw(5'h14, 32'h0);
    `CHK(resp, AMP_AXI_SLVERR)
    axw(AMP_C_IMASK, 32'h1);
    @(posedge aclk);
    `CHK(irq_out, 1'b1)
    axw(AMP_C_ISTAT, 32'h3);
    axw(AMP_C_IMASK, 32'h0);
    dev(0, AMP_OFS_IEN, 8'h00);
    `CHK(irq_out, 1'b0)
    $display("reset test done");
    for (int i = 0; i < 7; i++) begin
      dv = {2'($urandom_range(3)), 3'(i % 6), 3'(rates[i])};
      dev(1, AMP_OFS_WORD, dv);
      dev(1, AMP_OFS_FMT, {3'h2, 1'(i), 1'(i >> 1), 3'(i)});
      dev(0, AMP_OFS_WORD, 8'h00);
      dev(0, AMP_OFS_FMT, 8'h00);
      `CHK({o_wl, o_ratio, o_rate, o_ff, o_dsp, o_off}, {dv, 3'(i), 1'(i), 1'(i >> 1)})
    end
    dratio <= 3'($urandom_range(5));
    drate <= 3'(rates[$urandom_range(6)]);
    live <= 6'($urandom);
    dev(1, AMP_OFS_FMT, 8'h60);
    dev(0, AMP_OFS_WORD, 8'h00);
    `CHK({o_ratio, o_rate}, {dratio, drate})
    dev(1, AMP_OFS_LIVE, 8'hFF);
    dev(0, AMP_OFS_LIVE, 8'h00);
    dev(1, AMP_OFS_CSUM, 8'($urandom));
    dev(1, 8'h07, 8'h5A);
    dev(0, AMP_OFS_CSUM, 8'h00);
    dev(1, AMP_OFS_IEN, 8'($urandom));
    dev(0, AMP_OFS_IEN, 8'h00);
    $display("format test done");
    for (int k = 0; k < 8; k++) begin
      dev(1, AMP_OFS_IEN, 8'hFF);
      pulse(k);
      `CHK(u_amp_link_if.irq, 1'b1)
      dev(1, AMP_OFS_IEN, 8'(~(1 << k)));
      `CHK(u_amp_link_if.irq, 1'b0)
      dev(0, AMP_OFS_IFLAG, 8'h00);
      dev(0, AMP_OFS_IFLAG, 8'h00);
      dev(1, AMP_OFS_IFLAG, 8'h80);
      dev(0, AMP_OFS_IFLAG, 8'h00);
    end
    dev(1, AMP_OFS_IEN, 8'h00);
    pulse(0);
    `CHK(u_amp_link_if.irq, 1'b0)
    dev(1, AMP_OFS_FMT, 8'h20);
    pulse(6);
    dev(0, AMP_OFS_IFLAG, 8'h00);
    axr(AMP_C_ISTAT);
    `CHK(rd[1:0], 2'h3)
    $display("interrupt test done");
    dev(1, AMP_OFS_FMT, 8'hE0);
    repeat (340) @(posedge aclk);
    `CHK({o_bl, o_fl}, 2'h3)
    axw(AMP_C_CLK, 32'h1);
    repeat (320) @(posedge aclk);
    `CHK({o_bl, o_fl}, 2'h0)
    dev(1, AMP_OFS_FMT, 8'h60);
    axw(AMP_C_CLK, 32'h0);
    repeat (340) @(posedge aclk);
    `CHK({o_bl, o_fl}, 2'h0)
    $display("loss test done");
    report_and_stop();
  end
endmodule : tb_amp_irq_and_audio_format_regs
